/* hw/mss_selector.v */
// multi-step speed selector top
`timescale 1ns/1ps
// Notes on behaviour
// R1: sixteen preset speed references, zero to fifteen, are held.
// R2: the active preset is picked from the four speed-select terminals.
// R3: function codes 16 to 19 make an input speed-select terminal one to four.
// R4: function code 20 pauses multi-step running while the input is active.
// R5: each preset has a speed clamped to -300.0..300.0 percent and a running time, both reset to zero.
// R6: two 16-bit ramp selection words cover presets 0-7 and 8-15, reset to zero.
// R7: the executing stage number is reported and is zero after reset.
// R8: terminal one is the index lsb and terminal four the msb.
module mss_selector #(
	parameter N_IN = 6,
	parameter FW = 8,
	parameter SW = 16,
	parameter TW = 16
) (
	input wire clk_in, // control clock
	input wire nrst_in, // async reset, active low
	input wire [N_IN-1:0] din_in, // digital input terminals
	input wire [N_IN*FW-1:0] func_sel_in, // function select, first to last input
	input wire wr_en_in, // preset write strobe
	input wire [3:0] wr_idx_in, // preset index to write
	input wire [SW-1:0] wr_speed_in, // signed speed, 0.1 percent units
	input wire [TW-1:0] wr_time_in, // running time, 0.1 units
	input wire ramp_wr_low_in, // write low-steps ramp word
	input wire ramp_wr_high_in, // write high-steps ramp word
	input wire [15:0] ramp_data_in, // ramp word data
	output reg [SW-1:0] speed_ref_out, // active speed reference
	output reg [TW-1:0] run_time_out, // active running time
	output reg [1:0] ramp_sel_out, // active ramp selection
	output reg paused_out, // multi-step running paused
	output reg [3:0] present_stage_display_out, // executing stage
	output reg [15:0] ramp_select_low_steps_out, // ramp word, steps 0-7
	output reg [15:0] ramp_select_high_steps_out // ramp word, steps 8-15
);
`include "mss_defines.vh"

	// ==========================================================
	// clamp helper
	function [SW-1:0] mss_clamp;
		input [SW-1:0] v;
		begin
			if ($signed(v) > $signed(`MSS_SPEED_MAX)) mss_clamp = `MSS_SPEED_MAX;
			else if ($signed(v) < $signed(`MSS_SPEED_MIN)) mss_clamp = `MSS_SPEED_MIN;
			else mss_clamp = v;
		end
	endfunction

	// ==========================================================
	// local sizes
	localparam NP = `MSS_NUM_PRESETS; // preset count
	localparam IW = 4; // preset index width
	localparam SEL_W = 4; // speed-select terminal count

	// ==========================================================
	// two-bit ramp field of one step within its word
	function [1:0] mss_ramp_field;
		input [15:0] w;
		input [2:0] s;
		begin
			case (s)
				3'h0: mss_ramp_field = w[1:0];
				3'h1: mss_ramp_field = w[3:2];
				3'h2: mss_ramp_field = w[5:4];
				3'h3: mss_ramp_field = w[7:6];
				3'h4: mss_ramp_field = w[9:8];
				3'h5: mss_ramp_field = w[11:10];
				3'h6: mss_ramp_field = w[13:12];
				3'h7: mss_ramp_field = w[15:14];
				default: mss_ramp_field = 2'h0;
			endcase
		end
	endfunction

	// ==========================================================
	// input synchroniser, first stage
	reg [N_IN-1:0] sync1_reg;
	reg [N_IN-1:0] sync2_reg;
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1_reg <= {N_IN{1'b0}};
		end else begin
			sync1_reg <= din_in;
		end
	end

	// second stage, the only reader of the first
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync2_reg <= {N_IN{1'b0}};
		end else begin
			sync2_reg <= sync1_reg;
		end
	end

	// ==========================================================
	// terminal function decoding
	wire [SEL_W-1:0] sel; // speed-select levels, terminal one in bit 0
	wire pause; // pause level
	mss_term_decode #(.N_IN(N_IN), .FW(FW)) mss_term_decode_i ( // R3 R4 R8
		.din_in(sync2_reg),
		.func_in(func_sel_in),
		.sel_out(sel),
		.pause_out(pause)
	);

	// ==========================================================
	// preset storage
	reg [SW-1:0] speed_mem_reg [0:NP-1]; // R1
	reg [TW-1:0] time_mem_reg [0:NP-1]; // R1
	wire [SW-1:0] wr_speed_lim = mss_clamp(wr_speed_in); // R5
	integer k;
	integer m;

	// speed settings, clamped on the way in
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (k = 0; k < NP; k = k + 1) begin
				speed_mem_reg[k] <= `MSS_SPEED_RST; // R5
			end
		end else if (wr_en_in) begin
			speed_mem_reg[wr_idx_in] <= wr_speed_lim; // R5
		end
	end

	// running times, stored as given
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (m = 0; m < NP; m = m + 1) begin
				time_mem_reg[m] <= `MSS_TIME_RST; // R5
			end
		end else if (wr_en_in) begin
			time_mem_reg[wr_idx_in] <= wr_time_in; // R5
		end
	end

	// ramp selection word for steps 0-7
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ramp_select_low_steps_out <= `MSS_RAMP_RST; // R6
		end else if (ramp_wr_low_in) begin
			ramp_select_low_steps_out <= ramp_data_in; // R6
		end
	end

	// ramp selection word for steps 8-15
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ramp_select_high_steps_out <= `MSS_RAMP_RST; // R6
		end else if (ramp_wr_high_in) begin
			ramp_select_high_steps_out <= ramp_data_in; // R6
		end
	end

	// ==========================================================
	// stage selection, held while paused
	reg [IW-1:0] stage_next;
	reg [15:0] ramp_word;
	always @* begin
		if (pause) begin
			stage_next = present_stage_display_out; // R4
		end else begin
			stage_next = sel; // R2 R8
		end
	end

	// ramp word that covers the chosen step
	always @* begin
		if (stage_next[3]) begin
			ramp_word = ramp_select_high_steps_out; // R6
		end else begin
			ramp_word = ramp_select_low_steps_out; // R6
		end
	end

	// ==========================================================
	// output registers
	// executing stage number
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			present_stage_display_out <= `MSS_STAGE_RST; // R7
		end else begin
			present_stage_display_out <= stage_next; // R7
		end
	end

	// active speed; a fresh write shows one edge later
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			speed_ref_out <= `MSS_SPEED_RST;
		end else begin
			speed_ref_out <= speed_mem_reg[stage_next]; // R2
		end
	end

	// active running time
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			run_time_out <= `MSS_TIME_RST;
		end else begin
			run_time_out <= time_mem_reg[stage_next]; // R5
		end
	end

	// active ramp field
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ramp_sel_out <= 2'h0;
		end else begin
			ramp_sel_out <= mss_ramp_field(ramp_word, stage_next[2:0]); // R6
		end
	end

	// pause status
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			paused_out <= 1'b0;
		end else begin
			paused_out <= pause; // R4
		end
	end
endmodule // mss_selector

/* pkg/mss_defines.vh */
// constants for the multi-step speed selector
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH
`define MSS_NUM_PRESETS 16
`define MSS_NUM_INPUTS 6
`define MSS_FUNC_W 8
`define MSS_FUNC_TERM1 8'h10
`define MSS_FUNC_TERM2 8'h11
`define MSS_FUNC_TERM3 8'h12
`define MSS_FUNC_TERM4 8'h13
`define MSS_FUNC_PAUSE 8'h14
`define MSS_SPEED_W 16
`define MSS_SPEED_MAX 16'sh0BB8
`define MSS_SPEED_MIN (-16'sh0BB8)
`define MSS_SPEED_RST 16'h0000
`define MSS_TIME_W 16
`define MSS_TIME_RST 16'h0000
`define MSS_RAMP_W 16
`define MSS_RAMP_RST 16'h0000
`define MSS_STAGE_RST 4'h0
`endif

/* hw/mss_term_decode.v */
// terminal function decoder for speed-select and pause inputs
`timescale 1ns/1ps
module mss_term_decode #(
	parameter N_IN = 6,
	parameter FW = 8
) (
	input wire [N_IN-1:0] din_in, // synchronised input levels
	input wire [N_IN*FW-1:0] func_in, // function code per input
	output reg [3:0] sel_out, // speed-select terminal levels
	output reg pause_out // pause level
);
`include "mss_defines.vh"
	integer i;
	reg [FW-1:0] f;
	// or together active inputs per assigned function
	always @* begin
		sel_out = 4'h0;
		pause_out = 1'b0;
		f = {FW{1'b0}};
		for (i = 0; i < N_IN; i = i + 1) begin
			f = func_in[i*FW +: FW];
			if (din_in[i]) begin
				if (f == `MSS_FUNC_TERM1) sel_out[0] = 1'b1; // R3 R8
				else if (f == `MSS_FUNC_TERM2) sel_out[1] = 1'b1; // R3 R8
				else if (f == `MSS_FUNC_TERM3) sel_out[2] = 1'b1; // R3 R8
				else if (f == `MSS_FUNC_TERM4) sel_out[3] = 1'b1; // R3 R8
				else if (f == `MSS_FUNC_PAUSE) pause_out = 1'b1; // R4
			end
		end
	end
endmodule // mss_term_decode

/* bench/mss_selector_props.sv */
// checker on the speed selector ports
`timescale 1ns/1ps
module mss_selector_props (
	input wire clk_in, nrst_in, wr_en_in, ramp_wr_low_in, ramp_wr_high_in, paused_out, // ctl
	input wire [5:0] din_in, // terminals
	input wire [3:0] wr_idx_in, present_stage_display_out, // indices
	input wire [15:0] wr_speed_in, ramp_data_in, speed_ref_out, // data
	input wire [15:0] ramp_select_low_steps_out, ramp_select_high_steps_out // ramp words
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	lo_word_a: assert property (ramp_wr_low_in |=>
		ramp_select_low_steps_out == $past(ramp_data_in)) else $error("lo word");
	hi_word_a: assert property (ramp_wr_high_in |=>
		ramp_select_high_steps_out == $past(ramp_data_in)) else $error("hi word");
	speed_range_a: assert property (speed_ref_out + 16'h0BB8 <= 16'h1770) else $error("range");
	stage_reset_a: assert property ($rose(nrst_in) |-> present_stage_display_out == 4'h0)
		else $error("reset");
	pause_freeze_a: assert property (paused_out && $past(paused_out) |->
		$stable(present_stage_display_out)) else $error("freeze");
	stage_hold_a: assert property ($stable(din_in) [*5] |->
		$stable(present_stage_display_out)) else $error("stage");
	pause_hold_a: assert property ($stable(din_in) [*5] |-> $stable(paused_out))
		else $error("pause");
	preset_wr_a: assert property (wr_en_in && wr_idx_in == present_stage_display_out &&
		wr_speed_in + 16'h0BB8 <= 16'h1770 ##1 !wr_en_in && $stable(present_stage_display_out)
		##1 $stable(present_stage_display_out) |->
		speed_ref_out == $past(wr_speed_in, 2)) else $error("preset");
endmodule // mss_selector_props
bind mss_selector mss_selector_props mss_selector_props_i (.*);

/* bench/mss_term_model.sv */
// digital input terminals wired to their function slots
`timescale 1ns/1ps
module mss_term_model (
	input wire clk_in, // clock
	input wire [3:0] idx_in, // wanted step
	input wire pause_in, // pause request
	output reg [5:0] din_out = 6'h20 // terminal levels
);
	// slot order: pause, t4, t1, t3, t2, unused
	always @(posedge clk_in) din_out <= {1'b1, idx_in[1], idx_in[2], idx_in[0], idx_in[3], pause_in};
endmodule // mss_term_model

/* bench/mss_selector_bench.sv */
// self-checking bench for the speed selector
`timescale 1ns/1ps
module mss_selector_bench;
	logic clk_in = 0, nrst_in = 0, wr_en_in = 0, ramp_wr_low_in = 0, ramp_wr_high_in = 0, p = 0;
	logic paused_out;
	logic [1:0] ramp_sel_out;
	logic [3:0] wr_idx_in = 0, k = 0, present_stage_display_out;
	logic [15:0] wr_speed_in = 0, wr_time_in = 0, ramp_data_in = 0, speed_ref_out, run_time_out;
	logic [15:0] ramp_select_low_steps_out, ramp_select_high_steps_out;
	logic [47:0] func_sel_in = 48'h001112101314;
	wire [5:0] din_in;
	int n_fail = 0, checks_done = 0;
	always #25 clk_in = ~clk_in;
	mss_selector mss_selector_i (.*);
	mss_term_model mss_term_model_i (.clk_in, .idx_in(k), .pause_in(p), .din_out(din_in));
	task chk(string n, logic [15:0] s, e);
		checks_done++;
		n_fail += (s !== e);
		if (s !== e) $display("MISMATCH %s exp %h seen %h", n, e, s);
	endtask
	task go(logic [3:0] i, logic q);
		@(posedge clk_in) {k, p} <= {i, q};
		repeat (6) @(posedge clk_in);
		#1;
	endtask
	task wr(logic [3:0] i, logic [15:0] s);
		@(posedge clk_in) {wr_en_in, wr_idx_in, wr_speed_in, wr_time_in} <= {1'b1, i, s, 12'h000, i};
		@(posedge clk_in) wr_en_in <= 1'b0;
		#1;
	endtask
	task t_ramp;
		@(posedge clk_in) {ramp_wr_low_in, ramp_data_in} <= {1'b1, 16'hE4A5};
		@(posedge clk_in) {ramp_wr_low_in, ramp_wr_high_in, ramp_data_in} <= {2'b01, 16'h1B3C};
		@(posedge clk_in) ramp_wr_high_in <= 1'b0;
		#1;
		chk("lo", ramp_select_low_steps_out, 16'hE4A5);
		chk("hi", ramp_select_high_steps_out, 16'h1B3C);
	endtask
	task t_steps;
		for (int i = 0; i < 16; i++) wr(i, 16'(i * 100 - 800));
		wr(4'h0, 16'hF000);
		wr(4'hF, 16'h7FFF);
		for (int i = 0; i < 16; i++) begin
			go(i, 0);
			chk("stage", present_stage_display_out, 16'(i));
			chk("speed", speed_ref_out, i == 0 ? 16'hF448 : i == 15 ? 16'h0BB8 : 16'(i * 100 - 800));
			chk("time", run_time_out, 16'(i));
			chk("ramp", ramp_sel_out, 16'((32'h1B3CE4A5 >> 2 * i) & 3));
		end
	endtask
	task t_pause;
		go(5, 0);
		go(5, 1);
		go(9, 1);
		chk("held", present_stage_display_out, 16'h0005);
		chk("paused", paused_out, 16'h0001);
		wr(5, 16'h0123);
		chk("old", speed_ref_out, 16'hFED4);
		@(posedge clk_in);
		#1;
		chk("live", speed_ref_out, 16'h0123);
		go(9, 0);
		chk("resume", present_stage_display_out, 16'h0009);
		chk("unpaused", paused_out, 16'h0000);
		chk("speed9", speed_ref_out, 16'h0064);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b1;
		#1;
		chk("reset", present_stage_display_out, 16'h0000);
		t_ramp;
		t_steps;
		t_pause;
		tally_and_finish;
	end
	initial begin
		#100us;
		n_fail++;
		tally_and_finish;
	end
endmodule // mss_selector_bench
